// ===== src/trc_pkg.sv
// package: register map, fields, modes and carriers of the timer block
package trc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one byte per 32-bit word)
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 6;
  localparam logic [5:0]  OFS_CTRL   = 6'h00;
  localparam logic [5:0]  OFS_STAT   = 6'h04;
  localparam logic [5:0]  OFS_MASK   = 6'h08;
  localparam logic [5:0]  OFS_CNT_LO = 6'h0c;
  localparam logic [5:0]  OFS_CNT_HI = 6'h10;
  localparam logic [5:0]  OFS_RLD_LO = 6'h14;
  localparam logic [5:0]  OFS_RLD_HI = 6'h18;
  localparam logic [5:0]  OFS_PIN    = 6'h1c;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int          MODE_MSB   = 7;
  localparam int          MODE_LSB   = 5;
  localparam int          RUN_BIT    = 4;
  localparam int          PEND_BIT   = 0;
  localparam int          ENA_BIT    = 0;
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_CNT    = 16'h0000;
  localparam logic [15:0] RST_RLD    = 16'h0000;

  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  MODE_EVT_RISE = 3'h0;
  localparam logic [2:0]  MODE_EVT_FALL = 3'h1;
  localparam logic [2:0]  MODE_TMR      = 3'h4;
  localparam logic [2:0]  MODE_TMR_TGL  = 3'h5;
  localparam logic [2:0]  MODE_CAP_RISE = 3'h6;
  localparam logic [2:0]  MODE_CAP_FALL = 3'h7;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // carriers and state types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } trc_wr_s;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
  } trc_rd_s;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        pend;
    logic        ena;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic        pinOut;
  } trc_tmr_s;

endpackage

// ===== src/trc_edge_sync.sv
// pin synchroniser with single-cycle edge pulses
`timescale 1ns/10ps
module trc_edge_sync
  import trc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } trc_sync_s;

  trc_sync_s st;
  trc_sync_s next_st;

  // ---------------------------------------------------------------
  // two stages, then one delay for edges
  // ---------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.meta = pinIn;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // at most one edge per cycle
  assign level = st.sync;
  assign rise  = st.sync & ~st.prev; // RL19
  assign fall  = ~st.sync & st.prev; // RL19

endmodule

// ===== src/trc_axil_slave.sv
// axi4-lite slave turning bus words into byte register strobes
`timescale 1ns/10ps
module trc_axil_slave
  import trc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output trc_wr_s                wr,
  output trc_rd_s                rd,
  input  wire logic              wrHit,
  input  wire logic              rdHit,
  input  wire logic [7:0]        rdByte
);

  typedef struct packed {
    logic              awHeld;
    logic [ADDR_W-1:0] addr;
    logic              wHeld;
    logic [7:0]        data;
    logic              lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
  } trc_axi_s;

  trc_axi_s st;
  trc_axi_s next_st;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  assign awready = ~st.awHeld & ~st.bvalid;
  assign wready  = ~st.wHeld & ~st.bvalid;
  assign arready = ~st.rvalid;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign rvalid  = st.rvalid;
  assign rresp   = st.rresp;
  assign rdata   = {24'h000000, st.rdata};

  // one byte per access, lane 0 only
  assign wr.en   = st.awHeld & st.wHeld & st.lane0; // RL13
  assign wr.addr = st.addr;
  assign wr.data = st.data;
  assign rd.en   = arvalid & ~st.rvalid;
  assign rd.addr = araddr;

  // ---------------------------------------------------------------
  // address and data may come in either order
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (awvalid && awready) begin
      next_st.awHeld = 1'b1;
      next_st.addr   = awaddr;
    end
    if (wvalid && wready) begin
      next_st.wHeld = 1'b1;
      next_st.data  = wdata[7:0];
      next_st.lane0 = wstrb[0];
    end
    if (st.awHeld && st.wHeld) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (rd.en) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rdHit ? rdByte : 8'h00;
      next_st.rresp  = rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ===== src/trc_timer.sv
// 16-bit down timer/counter with reload/capture and axi4-lite registers
//
// Summary of operation
// RL1 - 16-bit counter and reload, byte read/write
// RL2 - control bits 7..5 select the mode
// RL3 - run bit gates counting, else holds
// RL4 - timer mode decrements, reloads on underflow
// RL5 - period is reload value plus one
// RL6 - toggle mode inverts pin on underflow
// RL7 - underflow is the timer event
// RL8 - event mode counts selected pin edges
// RL9 - pin source toggles at most half rate
// RL10 - capture mode copies count on pin edge
// RL11 - capture edge is the timer event
// RL12 - event sets pending, enable gates request
// RL13 - one byte per bus access
// RL14 - software stops counter before loading it
// RL15 - software reads high, low, maybe high
// RL16 - run bit one runs, zero stops
// RL17 - reset clears control and status
// RL18 - one pin: count input or toggle output
// RL19 - pin synchronised, one edge per cycle
`timescale 1ns/10ps
module trc_timer
  import trc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              timerPinIn,
  output logic                   timerPinOut,
  output logic                   timerPinOe,
  output logic                   irq
);

  trc_tmr_s    st;
  trc_tmr_s    next_st;
  trc_wr_s     wr;
  trc_rd_s     rd;
  logic        wrHit;
  logic        rdHit;
  logic [7:0]  rdByte;
  logic        pinLevel;
  logic        pinRise;
  logic        pinFall;
  logic [2:0]  mode;
  logic        run;
  logic        isEvt;
  logic        isTmr;
  logic        isCap;
  logic        pinEdge;
  logic        dec;
  logic        under;
  logic        capEv;
  logic        tmrEvent;

  // ---------------------------------------------------------------
  // bus slave and pin synchroniser
  // ---------------------------------------------------------------
  trc_axil_slave u_bus (
    .ref_clk (ref_clk),
    .reset   (reset),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr      (wr),
    .rd      (rd),
    .wrHit   (wrHit),
    .rdHit   (rdHit),
    .rdByte  (rdByte)
  );

  trc_edge_sync u_pin (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pinIn   (timerPinIn),
    .level   (pinLevel),
    .rise    (pinRise),
    .fall    (pinFall)
  );

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign mode    = st.ctrl[MODE_MSB:MODE_LSB]; // RL2
  assign run     = st.ctrl[RUN_BIT]; // RL16
  assign isEvt   = mode[2:1] == MODE_EVT_RISE[2:1]; // RL2
  assign isTmr   = mode[2:1] == MODE_TMR[2:1]; // RL2
  assign isCap   = mode[2:1] == MODE_CAP_RISE[2:1]; // RL2
  assign pinEdge = mode[0] ? pinFall : pinRise; // RL8 RL10

  // forbidden modes 01x never count
  assign dec   = run & (isTmr | isCap | (isEvt & pinEdge)); // RL3 RL8
  assign under = dec & ~isCap & (st.cnt == 16'h0000); // RL4 RL5
  assign capEv = run & isCap & pinEdge; // RL10
  assign tmrEvent = under | capEv; // RL7 RL11

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL, OFS_STAT, OFS_MASK, OFS_CNT_LO,
      OFS_CNT_HI, OFS_RLD_LO, OFS_RLD_HI: mapped = 1'b1;
      OFS_PIN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  assign wrHit = mapped(wr.addr);
  assign rdHit = mapped(rd.addr);

  // read mux, no read side effects
  always_comb begin
    case (rd.addr)
      OFS_CTRL:   rdByte = st.ctrl;
      OFS_STAT:   rdByte = {7'h00, st.pend};
      OFS_MASK:   rdByte = {7'h00, st.ena};
      OFS_CNT_LO: rdByte = st.cnt[7:0]; // RL1
      OFS_CNT_HI: rdByte = st.cnt[15:8]; // RL1
      OFS_RLD_LO: rdByte = st.rld[7:0]; // RL1
      OFS_RLD_HI: rdByte = st.rld[15:8]; // RL1
      OFS_PIN:    rdByte = {7'h00, pinLevel};
      default:    rdByte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // next state: counting first, then bus bytes override
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // count or reload
    if (dec) begin
      if (under) begin
        next_st.cnt = st.rld; // RL4 RL8
      end else begin
        next_st.cnt = st.cnt - 16'h0001; // RL4 RL10
      end
    end
    // current count into capture register
    if (capEv) begin
      next_st.rld = st.cnt; // RL10
    end
    // pin toggle on underflow
    if (under && mode == MODE_TMR_TGL) begin
      next_st.pinOut = ~st.pinOut; // RL6
    end
    // bus byte writes
    if (wr.en) begin
      case (wr.addr)
        OFS_CTRL:   next_st.ctrl = wr.data;
        OFS_MASK:   next_st.ena = wr.data[ENA_BIT];
        OFS_CNT_LO: next_st.cnt[7:0] = wr.data; // RL1 RL13
        OFS_CNT_HI: next_st.cnt[15:8] = wr.data; // RL1 RL13
        OFS_RLD_LO: next_st.rld[7:0] = wr.data; // RL1 RL13
        OFS_RLD_HI: next_st.rld[15:8] = wr.data; // RL1 RL13
        default:    next_st.ctrl = next_st.ctrl;
      endcase
    end
    // write one clears, a new event wins
    if (wr.en && wr.addr == OFS_STAT && wr.data[PEND_BIT]) begin
      next_st.pend = 1'b0;
    end
    if (tmrEvent) begin
      next_st.pend = 1'b1; // RL12
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st.ctrl   <= RST_CTRL; // RL17
      st.pend   <= 1'b0; // RL17
      st.ena    <= 1'b0; // RL17
      st.cnt    <= RST_CNT;
      st.rld    <= RST_RLD;
      st.pinOut <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign timerPinOut = st.pinOut;
  assign timerPinOe  = (mode == MODE_TMR_TGL); // RL18
  assign irq         = st.pend & st.ena; // RL12

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RELOAD: assert property ( // RL4
    @(posedge ref_clk) disable iff (reset)
    (isTmr && run && st.cnt == 16'h0000 && !wr.en)
      |=> (st.cnt == $past(st.rld)))
    else $error("underflow did not reload");

  AST_DECREMENT: assert property ( // RL4
    @(posedge ref_clk) disable iff (reset)
    (isTmr && run && st.cnt != 16'h0000 && !wr.en)
      |=> (st.cnt == $past(st.cnt) - 16'h0001))
    else $error("timer did not decrement");

  AST_HOLD_STOPPED: assert property ( // RL3
    @(posedge ref_clk) disable iff (reset)
    (!run && !wr.en) |=> $stable(st.cnt))
    else $error("stopped counter moved");

  AST_FORBID_HOLD: assert property ( // RL2
    @(posedge ref_clk) disable iff (reset)
    (mode[2:1] == 2'h1 && !wr.en) |=> $stable(st.cnt))
    else $error("forbidden mode counted");

  AST_TOGGLE: assert property ( // RL6
    @(posedge ref_clk) disable iff (reset)
    (under && mode == MODE_TMR_TGL) |=> (timerPinOut != $past(timerPinOut)))
    else $error("underflow did not toggle pin");

  AST_NO_TOGGLE: assert property ( // RL6
    @(posedge ref_clk) disable iff (reset)
    (mode != MODE_TMR_TGL) |=> $stable(timerPinOut))
    else $error("pin toggled outside toggle mode");

  AST_EVT_EDGE: assert property ( // RL8
    @(posedge ref_clk) disable iff (reset)
    (isEvt && run && !wr.en && st.cnt != 16'h0000 &&
     $rose(pinLevel) && mode == MODE_EVT_RISE)
      |=> (st.cnt == $past(st.cnt) - 16'h0001))
    else $error("event edge not counted");

  AST_CAPTURE: assert property ( // RL10
    @(posedge ref_clk) disable iff (reset)
    (capEv && !wr.en) |=> (st.rld == $past(st.cnt)))
    else $error("capture did not copy count");

  AST_PEND_SET: assert property ( // RL12
    @(posedge ref_clk) disable iff (reset)
    tmrEvent |=> st.pend ##0 (irq == st.ena))
    else $error("event did not set pending");

  AST_IRQ_GATE: assert property ( // RL12
    @(posedge ref_clk) disable iff (reset)
    irq |-> (st.pend && st.ena))
    else $error("request without pending and enable");

  // ---------------------------------------------------------------
  // event, capture and bus write checks
  // ---------------------------------------------------------------
  AST_EVT_FALL: assert property ( // RL8
    @(posedge ref_clk) disable iff (reset)
    (run && !wr.en && st.cnt != 16'h0000 && pinFall &&
     mode == MODE_EVT_FALL)
      |=> (st.cnt == $past(st.cnt) - 16'h0001))
    else $error("falling event edge not counted");

  AST_EVT_IDLE: assert property ( // RL8
    @(posedge ref_clk) disable iff (reset)
    (isEvt && !pinEdge && !wr.en) |=> $stable(st.cnt))
    else $error("event counter moved without an edge");

  AST_EVT_RELOAD: assert property ( // RL8
    @(posedge ref_clk) disable iff (reset)
    (isEvt && run && pinEdge && st.cnt == 16'h0000 && !wr.en)
      |=> (st.cnt == $past(st.rld)))
    else $error("event underflow did not reload");

  AST_CAP_COUNT: assert property ( // RL10
    @(posedge ref_clk) disable iff (reset)
    (isCap && run && !wr.en) |=> (st.cnt == $past(st.cnt) - 16'h0001))
    else $error("capture mode did not count down");

  AST_CAP_QUIET: assert property ( // RL11
    @(posedge ref_clk) disable iff (reset)
    (isCap && !pinEdge && !wr.en) |=> $stable(st.pend))
    else $error("capture mode raised event without edge");

  AST_RLD_HOLD: assert property ( // RL4
    @(posedge ref_clk) disable iff (reset)
    (!capEv && !wr.en) |=> $stable(st.rld))
    else $error("reload register changed on its own");

  AST_PEND_HOLD: assert property ( // RL12
    @(posedge ref_clk) disable iff (reset)
    (!tmrEvent && !wr.en) |=> $stable(st.pend))
    else $error("pending changed without event or write");

  AST_PEND_CLEAR: assert property ( // RL12
    @(posedge ref_clk) disable iff (reset)
    (wr.en && wr.addr == OFS_STAT && wr.data[PEND_BIT] && !tmrEvent)
      |=> !st.pend)
    else $error("pending not cleared by write");

  AST_FORBID_QUIET: assert property ( // RL2
    @(posedge ref_clk) disable iff (reset)
    (mode[2:1] == 2'h1) |-> !tmrEvent)
    else $error("forbidden mode raised an event");

  AST_STOP_QUIET: assert property ( // RL3
    @(posedge ref_clk) disable iff (reset)
    !run |-> !tmrEvent)
    else $error("stopped counter raised an event");

  AST_RUN_WRITE: assert property ( // RL16
    @(posedge ref_clk) disable iff (reset)
    (wr.en && wr.addr == OFS_CTRL) |=> (run == $past(wr.data[RUN_BIT])))
    else $error("run bit not taken from control write");

  AST_CNT_WRITE: assert property ( // RL13
    @(posedge ref_clk) disable iff (reset)
    (wr.en && wr.addr == OFS_CNT_HI) |=> (st.cnt[15:8] == $past(wr.data)))
    else $error("counter high byte write lost");

  AST_RLD_WRITE: assert property ( // RL1
    @(posedge ref_clk) disable iff (reset)
    (wr.en && wr.addr == OFS_RLD_LO) |=> (st.rld[7:0] == $past(wr.data)))
    else $error("reload low byte write lost");

endmodule

// ===== verification/trc_pin_model.sv
// pin source model: makes a burst of level changes on the timer pin
`timescale 1ns/10ps
module trc_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [3:0] nEdges,
  input  wire logic [3:0] halfPer,
  output logic            pinDrv,
  output logic            busy
);
  logic [3:0] left;
  logic [3:0] wt;
  initial begin
    pinDrv = 1'b0;
    left = 4'h0;
    wt = 4'h0;
  end
  assign busy = (left != 4'h0);
  // one change per half period, never below two clocks
  always @(posedge ref_clk) begin
    if (!busy && go) begin
      left <= nEdges;
      wt <= (halfPer < 4'h2) ? 4'h2 : halfPer;
    end else if (busy) begin
      if (wt == 4'h1) begin
        pinDrv <= ~pinDrv;
        left <= left - 4'h1;
        wt <= (halfPer < 4'h2) ? 4'h2 : halfPer;
      end else begin
        wt <= wt - 4'h1;
      end
    end
  end
endmodule

// ===== verification/tb_timer_reload_capture_counter.sv
// self-checking bench of the timer block over axi4-lite
`timescale 1ns/10ps
module tb_timer_reload_capture_counter;
  import trc_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, nEdges = 4'h0, halfPer = 4'h3;
  logic awready, wready, bvalid, arready, rvalid, irq, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic timerPinOut, timerPinOe, pinDrv, timerPinIn;
  int fail_count = 0, n_compared = 0, cycle = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cycle <= cycle + 1;
  // wire level from both drivers
  assign timerPinIn = timerPinOe ? timerPinOut : pinDrv;
  trc_timer trc_timer_inst (.ref_clk(ref_clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timerPinIn(timerPinIn), .timerPinOut(timerPinOut),
    .timerPinOe(timerPinOe), .irq(irq));
  trc_pin_model trc_pin_model_inst (.ref_clk(ref_clk), .go(go),
    .nEdges(nEdges), .halfPer(halfPer), .pinDrv(pinDrv), .busy(busy));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write one byte; payload held until its own ready
  task automatic axw(input logic [5:0] a, input logic [7:0] d,
                     output logic [1:0] rsp);
    int i;
    logic ha, hw, hb;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      rsp = bresp;
      @(posedge ref_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 40) chk(32'h0, 32'h1);
  endtask
  task automatic axr(input logic [5:0] a, output logic [31:0] d,
                     output logic [1:0] rsp);
    int i;
    logic ha, hr;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      rsp = rresp;
      @(posedge ref_clk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 40) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, {24'h0, e});
  endtask
  task automatic edges(input logic [3:0] n);
    @(posedge ref_clk);
    go <= 1'b1;
    nEdges <= n;
    halfPer <= 4'($urandom_range(2, 5));
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (100) @(posedge ref_clk) if (!busy) break;
    repeat (6) @(posedge ref_clk);
  endtask
  // next toggle of the pin output, in clocks
  task automatic nextToggle(output int t);
    logic last;
    last = timerPinOut;
    repeat (2000) begin
      @(negedge ref_clk);
      if (timerPinOut !== last) break;
    end
    t = cycle;
  endtask
  function automatic logic [15:0] dec(input logic [15:0] c,
    input logic [15:0] r, input int n, output logic uf);
    uf = 1'b0;
    for (int j = 0; j < n; j++) begin
      if (c == 16'h0) begin
        c = r;
        uf = 1'b1;
      end else c = c - 16'h1;
    end
    return c;
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    #240000;
    fail_count++;
    final_report();
  end
  initial begin
    logic [7:0] ev [5];
    logic [15:0] c, r, e;
    logic [31:0] d;
    logic [1:0] rsp;
    logic uf;
    int k, n, t0, t1;
    ev = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h00};
    void'($urandom(8));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (ev[i]) rdc(6'(4 * i), 8'h00);
    rdc(OFS_RLD_LO, 8'h00);
    rdc(OFS_RLD_HI, 8'h00);
    axr(6'h20, d, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // byte access of control, counter and reload registers, stopped
    repeat (3) begin
      c = 16'($urandom);
      wr(OFS_CTRL, c[7:0] & 8'h0f);
      rdc(OFS_CTRL, c[7:0] & 8'h0f);
      wr(OFS_CNT_LO, c[7:0]);
      wr(OFS_CNT_HI, c[15:8]);
      wr(OFS_RLD_LO, c[15:8]);
      wr(OFS_RLD_HI, c[7:0]);
      repeat (5) @(posedge ref_clk);
      rdc(OFS_CNT_LO, c[7:0]);
      rdc(OFS_CNT_HI, c[15:8]);
      rdc(OFS_RLD_LO, c[15:8]);
      rdc(OFS_RLD_HI, c[7:0]);
    end
    // event modes, forbidden modes and stopped counter
    foreach (ev[i]) begin
      c = 16'($urandom_range(0, 3));
      r = 16'($urandom);
      k = $urandom_range(1, 4);
      n = (i == 0) ? k : (i == 1) ? k - 1 : 0;
      e = dec(c, r, n, uf);
      wr(OFS_CNT_LO, c[7:0]);
      wr(OFS_CNT_HI, c[15:8]);
      wr(OFS_RLD_LO, r[7:0]);
      wr(OFS_RLD_HI, r[15:8]);
      wr(OFS_CTRL, ev[i]);
      edges(4'(2 * k - 1));
      wr(OFS_CTRL, ev[i] & 8'hef);
      rdc(OFS_PIN, 8'h01);
      rdc(OFS_CNT_LO, e[7:0]);
      rdc(OFS_CNT_HI, e[15:8]);
      rdc(OFS_STAT, {7'h0, uf});
      wr(OFS_STAT, 8'h01);
      edges(4'h1);
    end
    // toggle timer: period is reload plus one
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 16'h0 : 16'($urandom_range(2, 40));
      wr(OFS_CNT_LO, 8'h00);
      wr(OFS_CNT_HI, 8'h00);
      wr(OFS_RLD_LO, r[7:0]);
      wr(OFS_RLD_HI, r[15:8]);
      wr(OFS_CTRL, 8'hb0);
      chk({31'h0, timerPinOe}, 32'h1);
      @(negedge ref_clk);
      nextToggle(t0);
      nextToggle(t1);
      chk(32'(t1 - t0), 32'(r) + 32'h1);
      wr(OFS_CTRL, 8'ha0);
      rdc(OFS_STAT, 8'h01);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_MASK, 8'h01);
      @(negedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_STAT, 8'h01);
      rdc(OFS_STAT, 8'h00);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_MASK, 8'h00);
    end
    // running read: high, low, high again when low bit 7 set
    repeat (4) begin
      c = 16'h0100 + 16'($urandom_range(0, 12));
      wr(OFS_CNT_LO, c[7:0]);
      wr(OFS_CNT_HI, c[15:8]);
      wr(OFS_RLD_LO, 8'hff);
      wr(OFS_RLD_HI, 8'hff);
      wr(OFS_CTRL, 8'h90);
      axr(OFS_CNT_HI, d, rsp);
      e[15:8] = d[7:0];
      axr(OFS_CNT_LO, d, rsp);
      e[7:0] = d[7:0];
      if (e[7]) axr(OFS_CNT_HI, d, rsp);
      if (e[7]) e[15:8] = d[7:0];
      chk({31'h0, 16'(c - e) < 16'h0028}, 32'h1);
      wr(OFS_CTRL, 8'h80);
    end
    wr(OFS_CTRL, 8'h80);
    chk({31'h0, timerPinOe}, 32'h0);
    // capture on rising, then falling edge
    foreach (ev[i]) if (i < 2) begin
      wr(OFS_RLD_LO, 8'h00);
      wr(OFS_RLD_HI, 8'h00);
      wr(OFS_CNT_LO, 8'hff);
      wr(OFS_CNT_HI, 8'hff);
      wr(OFS_CTRL, (i == 0) ? 8'hd0 : 8'hf0);
      edges(4'h1);
      wr(OFS_CTRL, 8'hc0);
      axr(OFS_RLD_HI, d, rsp);
      chk(d, 32'h0000_00ff);
      rdc(OFS_STAT, 8'h01);
      wr(OFS_STAT, 8'h01);
    end
    final_report();
  end
endmodule
